//--- hw/pps_port_ctrl.sv
`timescale 1ns/1ps
module pps_port_ctrl #(
   parameter int unsigned UVLO_CYCLES = pps_pkg::UVLO_CYC,
   parameter int unsigned CLASS_CYCLES = 1000,
   parameter int unsigned MARK_CYCLES = 1000,
   parameter int unsigned STARTUP_CYCLES = 6000000,
   parameter int unsigned FAULT_CYCLES = 6000000,
   parameter int unsigned FAULT_DEC_DIV = 16,
   parameter int unsigned UNPLUG_CYCLES = 30000000,
   parameter int unsigned BLINK_ON_CYCLES = 25000000,
   parameter int unsigned BLINK_OFF_CYCLES = 25000000,
   parameter int unsigned BLINK_GAP_CYCLES = 100000000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic high_class_select_a,
   input wire logic high_class_select_b,
   input wire logic led_pwm_enable,
   input wire logic disconnect_mode_strap,
   input wire logic cadence_strap,
   input wire logic hicap_strap,
   input wire pps_pkg::pps_cmp_t cmp,
   input wire logic det_good,
   input wire logic det_bad,
   output pps_pkg::pps_ctl_t ctl,
   output logic detect_enable,
   output logic cadence_mode,
   output logic hicap_detect,
   output logic led_drive_en
);
   import pps_pkg::*;

   generate
      if (CLASS_CYCLES < 1 || MARK_CYCLES < 1 || STARTUP_CYCLES < 1 || FAULT_CYCLES < 2 ||
          FAULT_DEC_DIV < 2 || UNPLUG_CYCLES < 1 || UVLO_CYCLES < 1 || BLINK_ON_CYCLES < 1 ||
          BLINK_OFF_CYCLES < 1 || BLINK_GAP_CYCLES < 1) begin : g_bad
         $error("pps_port_ctrl: timing parameter out of range");
      end
   endgenerate

   // class from band comparators
   function automatic logic [2:0] cls_decode(input pps_cmp_t c, input logic c5);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (c.cls_above[i]) begin
            n = 3'(i + 1);
         end
      end
      if (c.cls_over_max && c5) begin
         n = 3'h5;
      end
      return n;
   endfunction

   // two-flop synchronisers for pins and comparators
   pps_cmp_t cmp_m, cmp_s;
   logic [5:0] pin_m, pin_s;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmp_m <= '0;
         cmp_s <= '0;
         pin_m <= 6'h3f;
         pin_s <= 6'h3f;
      end else begin
         cmp_m <= cmp;
         cmp_s <= cmp_m;
         pin_m <= {high_class_select_a, high_class_select_b, led_pwm_enable,
                   disconnect_mode_strap, cadence_strap, hicap_strap};
         pin_s <= pin_m;
      end
   end
   wire pwm_en_s = pin_s[3];

   // supply undervoltage qualification and thermal hysteresis
   logic [31:0] uv_cnt;
   logic sys_ok, therm_fault;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         uv_cnt <= 32'h0;
         sys_ok <= 1'b0;
         therm_fault <= 1'b0;
      end else begin
         uv_cnt <= !cmp_s.supply_above_uvlo ? 32'h0 : (sys_ok ? uv_cnt : uv_cnt + 32'h1);
         sys_ok <= cmp_s.supply_above_uvlo && (sys_ok || uv_cnt == 32'(UVLO_CYCLES));
         if (cmp_s.temp_hot) begin
            therm_fault <= 1'b1;
         end else if (cmp_s.temp_cool) begin
            therm_fault <= 1'b0;
         end
      end
   end
   wire core_rst = !sys_ok || therm_fault;

   // strap latches, open only while core_rst holds (undervoltage or thermal fault)
   logic c5_a, c5_b, ac_mode;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         c5_a <= 1'b0;
         c5_b <= 1'b0;
         ac_mode <= 1'b0;
         cadence_mode <= 1'b1;
         hicap_detect <= 1'b1;
      end else if (core_rst) begin
         c5_a <= !pin_s[5];
         c5_b <= !pin_s[4];
         ac_mode <= pin_s[2];
         cadence_mode <= pin_s[1];
         hicap_detect <= pin_s[0];
      end
   end
   wire c5_en = c5_a || c5_b;
   wire [1:0] c5_sel = {c5_b, c5_a};

   // register state
   logic [1:0] ctrl;
   pps_state_t state, next_state;
   logic [31:0] tmr, fault_cnt, disc_cnt, dec_div;
   logic [2:0] cls;
   logic blink2, blink5;
   wire port_en = ctrl[CTRL_PORT_EN];
   wire two_ev = ctrl[CTRL_TWO_EVENT];

   // classification result and its checks
   wire [2:0] cls_now = cls_decode(cmp_s, c5_en);
   wire cls_bad = cmp_s.cls_over_max && !c5_en;
   wire cls_end = tmr == 32'(CLASS_CYCLES - 1);
   wire mark_end = tmr == 32'(MARK_CYCLES - 1);

   // fault counting and disconnect sensing
   wire fault_inc = (state == PPS_START && cmp_s.over_limit) ||
                    (state == PPS_POWER && cmp_s.over_cut);
   wire fault_trip = fault_inc && fault_cnt == 32'(FAULT_CYCLES - 1);
   wire dec_tick = dec_div == 32'(FAULT_DEC_DIV - 1);
   wire under = ac_mode ? cmp_s.under_ac : cmp_s.under_dc;
   wire unplug = state == PPS_POWER && under && disc_cnt == 32'(UNPLUG_CYCLES);
   wire start_entry = state != PPS_START && next_state == PPS_START;

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         PPS_IDLE: begin
            if (port_en && !cmp_s.supply_over && fault_cnt == 32'h0 && det_good) begin
               next_state = PPS_CLS1;
            end
         end
         PPS_CLS1: begin
            if (cls_end) begin
               if (cls_bad) begin
                  next_state = PPS_REJECT;
               end else if (two_ev && cls_now >= 3'h4) begin
                  next_state = PPS_MARK1;
               end else begin
                  next_state = PPS_START;
               end
            end
         end
         PPS_MARK1: begin
            if (mark_end) begin
               next_state = PPS_MARK2;
            end
         end
         PPS_MARK2: begin
            if (mark_end) begin
               next_state = PPS_CLS2;
            end
         end
         PPS_CLS2: begin
            if (cls_end) begin
               next_state = cls_bad ? PPS_REJECT : PPS_START;
            end
         end
         PPS_START: begin
            if (fault_trip) begin
               next_state = PPS_COOL;
            end else if (tmr == 32'(STARTUP_CYCLES - 1)) begin
               next_state = PPS_POWER;
            end
         end
         PPS_POWER: begin
            if (fault_trip) begin
               next_state = PPS_COOL;
            end else if (unplug || !port_en) begin
               next_state = PPS_IDLE;
            end
         end
         PPS_COOL: begin
            if (fault_cnt == 32'h0) begin
               next_state = PPS_IDLE;
            end
         end
         PPS_REJECT: next_state = PPS_IDLE;
         default: next_state = PPS_IDLE;
      endcase
      if (cmp_s.supply_over && state != PPS_COOL) begin
         next_state = PPS_IDLE;
      end
   end

   // state, timer and class capture
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= PPS_IDLE;
         tmr <= 32'h0;
         cls <= 3'h0;
      end else if (core_rst) begin
         state <= PPS_IDLE;
         tmr <= 32'h0;
         cls <= 3'h0;
      end else begin
         state <= next_state;
         tmr <= (next_state != state) ? 32'h0 : tmr + 32'h1;
         if ((state == PPS_CLS1 || state == PPS_CLS2) && cls_end) begin
            cls <= cls_now;
         end
      end
   end

   // fault counter with slow decay, disconnect timer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_cnt <= 32'h0;
         dec_div <= 32'h0;
         disc_cnt <= 32'h0;
      end else begin
         dec_div <= dec_tick ? 32'h0 : dec_div + 32'h1;
         if (start_entry) begin
            fault_cnt <= 32'h0;
         end else if (fault_inc && !fault_trip) begin
            fault_cnt <= fault_cnt + 32'h1;
         end else if (!fault_inc && dec_tick && fault_cnt != 32'h0) begin
            fault_cnt <= fault_cnt - 32'h1;
         end
         if (state != PPS_POWER || !under) begin
            disc_cnt <= 32'h0;
         end else if (!unplug) begin
            disc_cnt <= disc_cnt + 32'h1;
         end
      end
   end

   // blink code flags, set wins over clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         blink2 <= 1'b0;
         blink5 <= 1'b0;
      end else begin
         blink2 <= fault_trip || (blink2 && state != PPS_POWER);
         blink5 <= det_bad || (blink5 && !det_good);
      end
   end

   // blink pattern: n flashes then a gap
   logic [31:0] bl_tmr;
   logic [2:0] bl_idx;
   logic bl_on;
   wire [2:0] bl_n = blink2 ? 3'h2 : 3'h5;
   wire [31:0] bl_len = bl_on ? 32'(BLINK_ON_CYCLES) :
                        (bl_idx == bl_n - 3'h1) ? 32'(BLINK_GAP_CYCLES) : 32'(BLINK_OFF_CYCLES);
   wire bl_step = bl_tmr >= bl_len - 32'h1;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bl_tmr <= 32'h0;
         bl_idx <= 3'h0;
         bl_on <= 1'b0;
      end else if (!(blink2 || blink5)) begin
         bl_tmr <= 32'h0;
         bl_idx <= 3'h0;
         bl_on <= 1'b1;
      end else if (bl_step) begin
         bl_tmr <= 32'h0;
         bl_on <= !bl_on;
         if (!bl_on) begin
            bl_idx <= (bl_idx >= bl_n - 3'h1) ? 3'h0 : bl_idx + 3'h1;
         end
      end else begin
         bl_tmr <= bl_tmr + 32'h1;
      end
   end

   // led pwm carrier and led drive
   logic [31:0] pwm_cnt;
   wire pwm_on = pwm_cnt < 32'(PWM_ON_CYC);
   wire powered = state == PPS_POWER;
   wire led_raw = powered ? 1'b1 : ((blink2 || blink5) && bl_on);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt <= 32'h0;
         led_drive_en <= 1'b0;
      end else begin
         pwm_cnt <= (pwm_cnt == 32'(PWM_PERIOD_CYC - 1)) ? 32'h0 : pwm_cnt + 32'h1;
         led_drive_en <= led_raw && (!pwm_en_s || pwm_on);
      end
   end

   // analog path controls
   wire gate = state == PPS_START || state == PPS_POWER;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= '0;
         detect_enable <= 1'b0;
      end else begin
         ctl.gate_on <= gate && !core_rst && !cmp_s.supply_over;
         ctl.regulate <= gate && cmp_s.over_limit;
         ctl.fast_pulldown <= gate && cmp_s.over_limit_2a;
         ctl.probe_class <= state == PPS_CLS1 || state == PPS_CLS2;
         ctl.probe_mark <= state == PPS_MARK1 || state == PPS_MARK2;
         ctl.startup_limit <= state == PPS_START;
         ctl.foldback <= !gate ? FB_NONE : cmp_s.port_below_10v ? FB_FLOOR :
                         cmp_s.port_below_27v ? FB_REDUCED : FB_NONE;
         ctl.cls <= cls;
         ctl.c5_sel <= c5_sel;
         detect_enable <= state == PPS_IDLE && !core_rst && port_en && fault_cnt == 32'h0;
      end
   end

   // apb decode and read mux
   wire apb_access = psel && penable;
   wire apb_setup = psel && !penable;
   wire hit_ctrl = paddr == REG_CTRL;
   wire mapped = hit_ctrl || paddr == REG_STATUS || paddr == REG_FAULT || paddr == REG_THRESH;
   wire [31:0] c5_thresh = (c5_sel == 2'h1) ? {C5A_CUT_MA, C5A_LIM_MA} :
                           (c5_sel == 2'h2) ? {C5B_CUT_MA, C5B_LIM_MA} :
                           (c5_sel == 2'h3) ? {C5AB_CUT_MA, C5AB_LIM_MA} : 32'h0;
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0;
      status_word[ST_STATE_LSB +: 4] = state;
      status_word[ST_CLASS_LSB +: 3] = cls;
      status_word[ST_C5_EN] = c5_en;
      status_word[ST_AC_MODE] = ac_mode;
      status_word[ST_OV] = cmp_s.supply_over;
      status_word[ST_THERM] = therm_fault;
      status_word[ST_BLINK2] = blink2;
      status_word[ST_BLINK5] = blink5;
      status_word[ST_POWERED] = powered;
      status_word[ST_SYS_OK] = sys_ok;
   end
   wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl} :
                        (paddr == REG_STATUS) ? status_word :
                        (paddr == REG_FAULT) ? fault_cnt :
                        (paddr == REG_THRESH) ?
                        ((state == PPS_START) ? {16'h0, STARTUP_LIM_MA} : c5_thresh) : 32'h0;
   assign pready = 1'b1;
   assign pslverr = apb_access && !mapped;

   // register writes in access phase, read capture in setup phase
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         prdata <= 32'h0;
      end else begin
         if (apb_access && pwrite && hit_ctrl) begin
            ctrl <= pwdata[1:0];
         end
         if (apb_setup) begin
            prdata <= rd_mux;
         end
      end
   end

   // checks
   property p_two_event;
      @(posedge clock) disable iff (!rst_n || core_rst)
      (state == PPS_CLS1 && cls_end && two_ev && cls_now >= 3'h4 && !cls_bad &&
       !cmp_s.supply_over) |=> state == PPS_MARK1;
   endproperty
   a_two_event: assert property (p_two_event) else $error("second event not begun");
   property p_marks;
      @(posedge clock) disable iff (!rst_n || core_rst)
      (state == PPS_MARK1 && mark_end && !cmp_s.supply_over) |=> state == PPS_MARK2 ##1
      ctl.probe_mark;
   endproperty
   a_marks: assert property (p_marks) else $error("mark sequence broken");
   property p_start_clear;
      @(posedge clock) disable iff (!rst_n)
      (state != PPS_START ##1 state == PPS_START) |-> fault_cnt == 32'h0 && disc_cnt == 32'h0;
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("timers not cleared");
   property p_trip;
      @(posedge clock) disable iff (!rst_n || core_rst)
      (fault_trip && !cmp_s.supply_over) |=> state == PPS_COOL ##1 !ctl.gate_on;
   endproperty
   a_trip: assert property (p_trip) else $error("fault did not power down");
   property p_cool_hold;
      @(posedge clock) disable iff (!rst_n || core_rst)
      (state == PPS_COOL && fault_cnt != 32'h0) |=> state == PPS_COOL;
   endproperty
   a_cool_hold: assert property (p_cool_hold) else $error("left cooldown early");
   property p_ov;
      @(posedge clock) disable iff (!rst_n)
      cmp_s.supply_over |=> !ctl.gate_on;
   endproperty
   a_ov: assert property (p_ov) else $error("gate on in overvoltage");
   property p_uvlo;
      @(posedge clock) disable iff (!rst_n)
      (!sys_ok || therm_fault) |=> !ctl.gate_on && state == PPS_IDLE;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("port on during reset");
   property p_reject;
      @(posedge clock) disable iff (!rst_n)
      state == PPS_REJECT |=> state == PPS_IDLE ##1 !ctl.gate_on;
   endproperty
   a_reject: assert property (p_reject) else $error("reject did not idle");
   property p_pwm;
      @(posedge clock) disable iff (!rst_n)
      (led_drive_en && $past(pwm_en_s)) |-> $past(pwm_cnt) < 32'(PWM_ON_CYC);
   endproperty
   a_pwm: assert property (p_pwm) else $error("led on outside pwm window");
endmodule

//--- hw/pps_pkg.sv
package pps_pkg;
   // clock and timing
   localparam int CLK_MHZ = 100;
   localparam real UVLO_TIME_MS = 2.5;
   localparam int UVLO_CYC = int'(UVLO_TIME_MS * 1000.0 * CLK_MHZ);
   localparam real PWM_FREQ_KHZ = 25.0;
   localparam real PWM_DUTY_PCT = 6.25;
   localparam int PWM_PERIOD_CYC = int'(CLK_MHZ * 1000.0 / PWM_FREQ_KHZ);
   localparam int PWM_ON_CYC = int'(PWM_PERIOD_CYC * PWM_DUTY_PCT / 100.0);
   // analog figures carried in the threshold register
   localparam logic [15:0] STARTUP_LIM_MA = 16'd420;
   localparam logic [15:0] C5A_CUT_MA = 16'd748;
   localparam logic [15:0] C5A_LIM_MA = 16'd850;
   localparam logic [15:0] C5B_CUT_MA = 16'd792;
   localparam logic [15:0] C5B_LIM_MA = 16'd900;
   localparam logic [15:0] C5AB_CUT_MA = 16'd836;
   localparam logic [15:0] C5AB_LIM_MA = 16'd950;
   // register map
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_FAULT = 12'h008;
   localparam logic [11:0] REG_THRESH = 12'h00c;
   localparam int CTRL_PORT_EN = 0;
   localparam int CTRL_TWO_EVENT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CLASS_LSB = 4;
   localparam int ST_C5_EN = 7;
   localparam int ST_AC_MODE = 8;
   localparam int ST_OV = 9;
   localparam int ST_THERM = 10;
   localparam int ST_BLINK2 = 11;
   localparam int ST_BLINK5 = 12;
   localparam int ST_POWERED = 13;
   localparam int ST_SYS_OK = 14;
   // foldback levels
   localparam logic [1:0] FB_NONE = 2'h0;
   localparam logic [1:0] FB_REDUCED = 2'h1;
   localparam logic [1:0] FB_FLOOR = 2'h2;

   typedef enum logic [3:0] {
      PPS_IDLE = 4'h0, PPS_CLS1 = 4'h1, PPS_MARK1 = 4'h2, PPS_MARK2 = 4'h3,
      PPS_CLS2 = 4'h4, PPS_START = 4'h5, PPS_POWER = 4'h6, PPS_COOL = 4'h7,
      PPS_REJECT = 4'h8
   } pps_state_t;

   // comparator inputs from the analog front end
   typedef struct packed {
      logic over_limit;
      logic over_limit_2a;
      logic over_cut;
      logic under_dc;
      logic under_ac;
      logic port_below_27v;
      logic port_below_10v;
      logic supply_above_uvlo;
      logic supply_over;
      logic temp_hot;
      logic temp_cool;
      logic [3:0] cls_above;
      logic cls_over_max;
   } pps_cmp_t;

   // controls to the analog power path
   typedef struct packed {
      logic gate_on;
      logic regulate;
      logic fast_pulldown;
      logic probe_class;
      logic probe_mark;
      logic startup_limit;
      logic [1:0] foldback;
      logic [2:0] cls;
      logic [1:0] c5_sel;
   } pps_ctl_t;
endpackage

//--- verif/pps_pd_model.sv
`timescale 1ns/1ps
// powered device, cable and supply seen as comparator levels
module pps_pd_model (
   input wire pps_pkg::pps_ctl_t ctl,
   input wire logic [2:0] cls_code,
   input wire logic [3:0] load,
   input wire logic [2:0] env,
   input wire logic [1:0] droop,
   output pps_pkg::pps_cmp_t cmp
);
   import pps_pkg::*;
   logic on;
   assign on = ctl.gate_on;
   // class current only flows while probed; load current only while powered
   always_comb begin
      cmp = '0;
      if (ctl.probe_class) begin
         for (int i = 0; i < 4; i++) cmp.cls_above[i] = (cls_code > i);
         cmp.cls_over_max = (cls_code == 3'h5);
      end
      cmp.over_limit = on & load[0];
      cmp.over_cut = on & load[0];
      cmp.over_limit_2a = on & load[1];
      cmp.under_dc = ~on | load[2];
      cmp.under_ac = ~on | load[3];
      cmp.port_below_27v = ~on | droop[0];
      cmp.port_below_10v = ~on | droop[1];
      cmp.supply_above_uvlo = env[0];
      cmp.supply_over = env[1];
      cmp.temp_hot = env[2];
      cmp.temp_cool = ~env[2];
   end
endmodule

//--- verif/pps_port_ctrl_tb.sv
`timescale 1ns/1ps
module pps_port_ctrl_tb;
   import pps_pkg::*;
   localparam int UV = 20;
   localparam int MK = 5;
   localparam int FT = 40;
   typedef struct packed {
      logic a;
      logic b;
      logic [2:0] c;
      logic [31:0] th;
   } pps_row_t;
   logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic sel_a = 1'h1, sel_b = 1'h1, pwm_en = 1'h0, dstrap = 1'h0, cad = 1'h1, hicap = 1'h1;
   logic hicap_detect, detect_enable;
   logic det_good = 1'h0, det_bad = 1'h0, pready, pslverr, led_drive_en, cadence_mode, se;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [2:0] cls = 3'h0, env = 3'h1;
   logic [3:0] load = 4'h0;
   logic [1:0] droop = 2'h0;
   pps_cmp_t cmp;
   pps_ctl_t ctl;
   int error_cnt = 0, tests_run = 0, marks = 0, cycles = 0, n;
   pps_row_t rows [6] = '{'{1'h1, 1'h1, 3'h0, 32'h0}, '{1'h1, 1'h1, 3'h2, 32'h0},
      '{1'h1, 1'h1, 3'h4, 32'h0}, '{1'h0, 1'h1, 3'h5, {C5A_CUT_MA, C5A_LIM_MA}},
      '{1'h1, 1'h0, 3'h5, {C5B_CUT_MA, C5B_LIM_MA}},
      '{1'h0, 1'h0, 3'h3, {C5AB_CUT_MA, C5AB_LIM_MA}}};
   // device with shortened counts
   pps_port_ctrl #(.UVLO_CYCLES(UV), .CLASS_CYCLES(5), .MARK_CYCLES(MK), .STARTUP_CYCLES(50),
      .FAULT_CYCLES(FT), .FAULT_DEC_DIV(4), .UNPLUG_CYCLES(30), .BLINK_ON_CYCLES(8),
      .BLINK_OFF_CYCLES(8), .BLINK_GAP_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_class_select_a(sel_a),
      .high_class_select_b(sel_b), .led_pwm_enable(pwm_en), .disconnect_mode_strap(dstrap),
      .cadence_strap(cad), .hicap_strap(hicap), .cmp(cmp), .det_good(det_good),
      .det_bad(det_bad), .ctl(ctl), .detect_enable(detect_enable),
      .cadence_mode(cadence_mode), .hicap_detect(hicap_detect),
      .led_drive_en(led_drive_en));
   // far side of the port
   pps_pd_model pd (.ctl(ctl), .cls_code(cls), .load(load), .env(env), .droop(droop),
      .cmp(cmp));
   // clock
   initial begin
      forever #5 clock = ~clock;
   end
   // mark probe cycles and run bound
   always @(posedge clock) begin
      if (ctl.probe_mark === 1'h1) marks <= marks + 1;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         error_cnt++;
         $display("ERROR timeout expected end seen hang");
         end_sim();
      end
   end
   task automatic end_sim;
      $display("tests %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      tests_run++;
      if (v !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      q = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic wst(input logic [3:0] s);
      n = 0;
      do begin
         apb(1'h0, REG_STATUS, 32'h0);
         n++;
      end while (q[3:0] !== s && n < 100);
      chk("state", s, q[3:0]);
   endtask
   task automatic probe_node;
      det_good <= 1'h1;
      @(posedge clock);
      det_good <= 1'h0;
   endtask
   task automatic pwr(input logic [2:0] c);
      cls <= c;
      probe_node();
      wst(PPS_START);
      apb(1'h0, REG_THRESH, 32'h0);
      chk("thr_start", {16'h0, STARTUP_LIM_MA}, q);
      chk("start_lim", 1, ctl.startup_limit);
      wst(PPS_POWER);
   endtask
   task automatic boot(input logic a, input logic b, input logic d);
      rst_n <= 1'h0;
      sel_a <= a;
      sel_b <= b;
      dstrap <= d;
      env <= 3'h1;
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      apb(1'h0, REG_STATUS, 32'h0);
      chk("uvlo_hold", 0, q[ST_SYS_OK]);
      repeat (UV + 10) @(posedge clock);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("sys_ok", 1, q[ST_SYS_OK]);
   endtask
   initial begin
      foreach (rows[i]) begin
         boot(rows[i].a, rows[i].b, 1'h0);
         chk("c5_en", !(rows[i].a & rows[i].b), q[ST_C5_EN]);
         pwr(rows[i].c);
         apb(1'h0, REG_STATUS, 32'h0);
         chk("class", rows[i].c, q[6:4]);
         apb(1'h0, REG_THRESH, 32'h0);
         chk("thr", rows[i].th, q);
         chk("ctl_cls", {!rows[i].b, !rows[i].a, rows[i].c}, {ctl.c5_sel, ctl.cls});
         chk("led", 1, led_drive_en);
         chk("one_event", 0, marks);
         done("class row");
      end
      cad <= 1'h0;
      hicap <= 1'h0;
      apb(1'h0, REG_CTRL, 32'h0);
      chk("ctrl_rst", CTRL_RESET, q[1:0]);
      apb(1'h0, 12'h010, 32'h0);
      chk("slverr", 1, se);
      chk("unmapped", 0, q);
      chk("cadence", 1, cadence_mode);
      chk("hicap", 1, hicap_detect);
      pwm_en <= 1'h1;
      repeat (4) @(posedge clock);
      n = 0;
      repeat (PWM_PERIOD_CYC) begin
         @(posedge clock);
         if (led_drive_en === 1'h1) n++;
      end
      chk("pwm_on", PWM_ON_CYC, n);
      pwm_en <= 1'h0;
      droop <= 2'h1;
      repeat (5) @(posedge clock);
      chk("fold_red", FB_REDUCED, ctl.foldback);
      droop <= 2'h3;
      repeat (5) @(posedge clock);
      chk("fold_floor", FB_FLOOR, ctl.foldback);
      droop <= 2'h0;
      done("regs led foldback");
      load <= 4'h3;
      repeat (30) @(posedge clock);
      chk("regulate", 1, ctl.regulate);
      chk("pulldown", 1, ctl.fast_pulldown);
      chk("no_trip", 1, ctl.gate_on);
      load <= 4'h0;
      repeat (8) @(posedge clock);
      load <= 4'h1;
      repeat (30) @(posedge clock);
      chk("trip", 0, ctl.gate_on);
      load <= 4'h0;
      apb(1'h0, REG_STATUS, 32'h0);
      chk("blink2", 1, q[ST_BLINK2]);
      apb(1'h0, REG_FAULT, 32'h0);
      chk("fault_kept", 1, q != 0);
      probe_node();
      repeat (20) @(posedge clock);
      chk("refused", 0, ctl.gate_on);
      chk("det_off", 0, detect_enable);
      repeat (4 * FT) @(posedge clock);
      apb(1'h0, REG_FAULT, 32'h0);
      chk("fault_zero", 0, q);
      chk("det_on", 1, detect_enable);
      pwr(3'h4);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("blink2_clr", 0, q[ST_BLINK2]);
      done("overload");
      apb(1'h1, REG_CTRL, 32'h2);
      apb(1'h1, REG_CTRL, 32'h3);
      pwr(3'h2);
      chk("marks_c2", 0, marks);
      apb(1'h1, REG_CTRL, 32'h2);
      apb(1'h1, REG_CTRL, 32'h3);
      pwr(3'h4);
      chk("marks_c4", 2 * MK, marks);
      load <= 4'h8;
      repeat (45) @(posedge clock);
      chk("dc_keeps", 1, ctl.gate_on);
      load <= 4'h4;
      repeat (25) @(posedge clock);
      chk("dc_hold", 1, ctl.gate_on);
      repeat (20) @(posedge clock);
      chk("dc_unplug", 0, ctl.gate_on);
      chk("led_off", 0, led_drive_en);
      load <= 4'h0;
      done("two event and dc unplug");
      pwr(3'h1);
      env <= 3'h3;
      repeat (6) @(posedge clock);
      chk("ov_off", 0, ctl.gate_on);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("ov_flag", 1, q[ST_OV]);
      env <= 3'h1;
      // overvoltage must clear the synchroniser before detection is accepted
      repeat (3) @(posedge clock);
      pwr(3'h1);
      env <= 3'h5;
      repeat (6) @(posedge clock);
      chk("hot_off", 0, ctl.gate_on);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("hot_flag", 1, q[ST_THERM]);
      env <= 3'h1;
      repeat (UV + 10) @(posedge clock);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("hot_clear", 32'h1, {q[ST_THERM], q[ST_SYS_OK]});
      chk("cad_relatch", 0, cadence_mode);
      done("supply and thermal");
      boot(1'h1, 1'h1, 1'h1);
      chk("ac_mode", 1, q[ST_AC_MODE]);
      chk("hicap_boot", 0, hicap_detect);
      pwr(3'h1);
      load <= 4'h4;
      repeat (45) @(posedge clock);
      chk("ac_keeps", 1, ctl.gate_on);
      load <= 4'h8;
      repeat (45) @(posedge clock);
      chk("ac_unplug", 0, ctl.gate_on);
      load <= 4'h0;
      cls <= 3'h5;
      probe_node();
      repeat (30) @(posedge clock);
      chk("c5_off_reject", 0, ctl.gate_on);
      wst(PPS_IDLE);
      det_bad <= 1'h1;
      @(posedge clock);
      det_bad <= 1'h0;
      apb(1'h0, REG_STATUS, 32'h0);
      chk("blink5", 1, q[ST_BLINK5]);
      done("ac unplug and reject");
      end_sim();
   end
endmodule
